// ### rcpc_operator.sv
// Purpose: Crew operator at the panel, pressing the momentary cycle switch.
// Assumes: Requests arrive one at a time, just after a clock edge.
// Notes:   Each press is held for HOLD cycles, then released.
`timescale 1ns/1ps
module rcpc_operator #(
  parameter int HOLD = 6
) (
  input  wire logic clk_i,
  input  wire logic press_start_i,
  input  wire logic press_shut_i,
  output logic      start_btn_o,
  output logic      shutdown_btn_o
);
  // ==========================================================================
  // Press and release
  int hold = 0;
  initial begin
    start_btn_o = 1'b0;
    shutdown_btn_o = 1'b0;
  end
  // A release always follows, since the controller acts on the press edge only.
  always @(posedge clk_i) begin
    if (hold > 1) begin
      hold <= hold - 1;
    end else if (hold == 1) begin
      hold <= 0;
      start_btn_o <= 1'b0;
      shutdown_btn_o <= 1'b0;
    end else if (press_start_i || press_shut_i) begin
      hold <= HOLD;
      start_btn_o <= press_start_i;
      shutdown_btn_o <= press_shut_i;
    end
  end
endmodule // rcpc_operator

// ### rcpc_panel.sv
// Purpose: Front-panel cycle control, lamps and display for a regeneration oven.
// Assumes: All panel and sensor inputs are asynchronous levels.
// Notes:   resetn_i is the power-on reset; power_sw_i is the panel switch.
`timescale 1ns/1ps
module rcpc_panel #(
  parameter int              TICK_CYC    = rcpc_pkg::TICK_CYC,
  parameter logic [15:0]     HEAT_S      = rcpc_pkg::HEAT_S,
  parameter logic [15:0]     COOL_S      = rcpc_pkg::COOL_S,
  parameter logic [15:0]     ABORT_S     = rcpc_pkg::ABORT_COOL_S,
  parameter logic [15:0]     PAUSE_MAX_S = rcpc_pkg::PAUSE_MAX_S,
  parameter logic [15:0]     START_TO_S  = rcpc_pkg::START_TO_S
) (
  input  wire logic                           clk_i,
  input  wire logic                           resetn_i,
  input  wire logic                           power_sw_i,
  input  wire logic                           run_sel_i,
  input  wire logic                           start_btn_i,
  input  wire logic                           shutdown_btn_i,
  input  wire logic                           bypass_sw_i,
  input  wire logic                           remote_pause_i,
  input  wire logic                           door_closed_i,
  input  wire logic                           door_open90_i,
  input  wire logic                           valve_cool_i,
  input  wire logic [rcpc_pkg::NFAULT-1:0]    fault_i,
  input  wire logic [rcpc_pkg::NFAULT-1:0]    hazard_i,
  input  wire logic [rcpc_pkg::TEMPW-1:0]     oven_temp_i,
  output logic                                heater_en_o,
  output logic                                fan_en_o,
  output logic                                valve_cool_cmd_o,
  output logic                                door_unlatch_o,
  output logic                                lamp_bypass_o,
  output logic                                lamp_heat_o,
  output logic                                lamp_cool_o,
  output logic                                lamp_done_o,
  output logic                                lamp_local_pause_o,
  output logic                                lamp_remote_pause_o,
  output logic                                lamp_hot_o,
  output logic                                lamp_abort_run_o,
  output logic                                lamp_abort_done_o,
  output logic                                lamp_pwr_int_o,
  output logic                                lamp_valve_o,
  output logic [rcpc_pkg::NFAULT-1:0]         lamp_fault_o,
  output logic [1:0]                          disp_mode_o,
  output logic [7:0]                          disp_code_o,
  output logic [15:0]                         disp_time_o
);

  // ==========================================================================
  // Input synchronisation and tick
  localparam int SW = 10 + 2 * rcpc_pkg::NFAULT + rcpc_pkg::TEMPW;
  logic [SW-1:0]                    sync_q;
  logic                             s_pwr;
  logic                             s_run;
  logic                             s_start;
  logic                             s_shut;
  logic                             s_byp;
  logic                             s_remote;
  logic                             s_door;
  logic                             s_open90;
  logic                             s_vcool;
  logic                             s_spare;
  logic [rcpc_pkg::NFAULT-1:0]      s_fault;
  logic [rcpc_pkg::NFAULT-1:0]      s_haz;
  logic [rcpc_pkg::TEMPW-1:0]       s_temp;
  logic                             tick;

  rcpc_sync #(.W(SW)) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      ({power_sw_i, run_sel_i, start_btn_i, shutdown_btn_i, bypass_sw_i,
                remote_pause_i, door_closed_i, door_open90_i, valve_cool_i, 1'b0,
                fault_i, hazard_i, oven_temp_i}),
    .q_o      (sync_q)
  );

  assign {s_pwr, s_run, s_start, s_shut, s_byp, s_remote, s_door, s_open90,
          s_vcool, s_spare, s_fault, s_haz, s_temp} = sync_q;

  rcpc_tick #(.DIV(TICK_CYC)) u_tick (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .tick_o   (tick)
  );

  // ==========================================================================
  // Cycle control
  rcpc_pkg::rcpc_state_t state_r, state_nxt;
  logic [15:0] remain_r, remain_nxt;
  logic [15:0] pause_r, pause_nxt;
  logic [15:0] wait_r, wait_nxt;
  logic [3:0]  test_r, test_nxt;
  logic        abort_r, abort_nxt;
  logic        term_r, term_nxt;
  logic        tmo_r, tmo_nxt;
  logic        reopen_r, reopen_nxt;
  logic        pcyc_r, pcyc_nxt;
  logic        pwrint_r, pwrint_nxt;
  logic        start_d_r, shut_d_r, pwr_d_r;
  logic        start_ev;
  logic        shut_ev;
  logic        pwr_rise;
  logic        paused;
  logic        eff_fault;

  always_comb begin
    start_ev  = s_start & ~start_d_r & s_pwr;
    shut_ev   = s_shut & ~shut_d_r & s_pwr;
    pwr_rise  = s_pwr & ~pwr_d_r;
    paused    = ~s_run | s_remote;
    // Bypass masks only the faults not flagged hazardous.
    eff_fault = |(s_fault & (s_haz | {rcpc_pkg::NFAULT{~s_byp}}));
    state_nxt  = state_r;
    remain_nxt = remain_r;
    pause_nxt  = pause_r;
    wait_nxt   = wait_r;
    abort_nxt  = abort_r;
    term_nxt   = term_r;
    tmo_nxt    = tmo_r;
    reopen_nxt = reopen_r;
    pcyc_nxt   = pcyc_r;
    pwrint_nxt = pwrint_r;
    test_nxt   = test_r;
    if (pwr_rise) begin
      test_nxt = rcpc_pkg::SELFTEST_S;
    end else if (tick && test_r != 4'h0) begin
      test_nxt = test_r - 4'h1;
    end
    case (state_r)
      rcpc_pkg::ST_IDLE, rcpc_pkg::ST_DONE: begin
        if (!s_door || !s_pwr) begin
          wait_nxt = 16'h0000;
        end else if (tick && wait_r != START_TO_S) begin
          wait_nxt = wait_r + 16'h0001;
        end
        if (state_r == rcpc_pkg::ST_IDLE && wait_r == START_TO_S) begin
          tmo_nxt = 1'b1;
        end
        if (!s_pwr) begin
          state_nxt = rcpc_pkg::ST_IDLE;
        end else if (start_ev && s_vcool) begin
          state_nxt  = rcpc_pkg::ST_INITF;
          reopen_nxt = 1'b0;
          pcyc_nxt   = 1'b0;
        end else if (start_ev) begin
          state_nxt  = rcpc_pkg::ST_HEAT;
          remain_nxt = HEAT_S + COOL_S;
          pause_nxt  = 16'h0000;
          abort_nxt  = 1'b0;
          term_nxt   = 1'b0;
          tmo_nxt    = 1'b0;
          pwrint_nxt = 1'b0;
        end
      end
      rcpc_pkg::ST_HEAT: begin
        if (!s_pwr) begin
          state_nxt  = rcpc_pkg::ST_IDLE;
          pwrint_nxt = 1'b1;
        end else if (shut_ev) begin
          state_nxt  = rcpc_pkg::ST_COOL;
          remain_nxt = ABORT_S;
          abort_nxt  = 1'b1;
        end else if (paused) begin
          if (tick && pause_r == PAUSE_MAX_S) begin
            state_nxt = rcpc_pkg::ST_DONE;
            term_nxt  = 1'b1;
          end else if (tick) begin
            pause_nxt = pause_r + 16'h0001;
          end
        end else begin
          pause_nxt = 16'h0000;
          if (remain_r <= COOL_S) begin
            state_nxt = rcpc_pkg::ST_COOL;
          end else if (tick && !eff_fault) begin
            remain_nxt = remain_r - 16'h0001;
          end
        end
      end
      rcpc_pkg::ST_COOL: begin
        if (!s_pwr) begin
          state_nxt  = rcpc_pkg::ST_IDLE;
          pwrint_nxt = 1'b1;
        end else begin
          if (shut_ev) begin
            abort_nxt = 1'b1;
          end
          if (remain_r == 16'h0000) begin
            state_nxt = rcpc_pkg::ST_DONE;
          end else if (tick && !paused && !eff_fault) begin
            remain_nxt = remain_r - 16'h0001;
          end
        end
      end
      rcpc_pkg::ST_INITF: begin
        // The fault outlives the panel switch; only the full sequence frees it.
        if (s_open90) begin
          reopen_nxt = 1'b1;
        end
        if (pwr_rise && reopen_r) begin
          pcyc_nxt = 1'b1;
        end
        if (start_ev && pcyc_r) begin
          reopen_nxt = 1'b0;
          pcyc_nxt   = 1'b0;
          tmo_nxt    = 1'b0;
          if (!s_vcool) begin
            state_nxt  = rcpc_pkg::ST_HEAT;
            remain_nxt = HEAT_S + COOL_S;
            pause_nxt  = 16'h0000;
            abort_nxt  = 1'b0;
            term_nxt   = 1'b0;
            pwrint_nxt = 1'b0;
          end
        end
      end
      default: begin
        state_nxt = rcpc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r   <= rcpc_pkg::ST_IDLE;
      remain_r  <= 16'h0000;
      pause_r   <= 16'h0000;
      wait_r    <= 16'h0000;
      test_r    <= rcpc_pkg::SELFTEST_S;
      abort_r   <= 1'b0;
      term_r    <= 1'b0;
      tmo_r     <= 1'b0;
      reopen_r  <= 1'b0;
      pcyc_r    <= 1'b0;
      pwrint_r  <= 1'b0;
      start_d_r <= 1'b0;
      shut_d_r  <= 1'b0;
      pwr_d_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      remain_r  <= remain_nxt;
      pause_r   <= pause_nxt;
      wait_r    <= wait_nxt;
      test_r    <= test_nxt;
      abort_r   <= abort_nxt;
      term_r    <= term_nxt;
      tmo_r     <= tmo_nxt;
      reopen_r  <= reopen_nxt;
      pcyc_r    <= pcyc_nxt;
      pwrint_r  <= pwrint_nxt;
      start_d_r <= s_start;
      shut_d_r  <= s_shut;
      pwr_d_r   <= s_pwr;
    end
  end

  // ==========================================================================
  // Lamps, drives and display
  logic        heat_nxt, fan_nxt, vcmd_nxt, unl_nxt, byp_nxt;
  logic        lh_nxt, lc_nxt, ld_nxt, lp_nxt, lr_nxt, hot_nxt;
  logic        ar_nxt, ad_nxt, pi_nxt, lv_nxt;
  logic [rcpc_pkg::NFAULT-1:0] lf_nxt;
  logic [1:0]  dm_nxt;
  logic [7:0]  dc_nxt;
  logic        in_heat, in_cool, in_done, in_initf;

  always_comb begin
    in_heat  = (state_r == rcpc_pkg::ST_HEAT);
    in_cool  = (state_r == rcpc_pkg::ST_COOL);
    in_done  = (state_r == rcpc_pkg::ST_DONE);
    in_initf = (state_r == rcpc_pkg::ST_INITF);
    heat_nxt = in_heat & ~paused & ~eff_fault;
    fan_nxt  = ((in_heat & ~paused) | in_cool) & ~eff_fault;
    vcmd_nxt = tmo_r | in_cool | in_done | in_initf;
    unl_nxt  = in_done;
    byp_nxt  = s_byp;
    lh_nxt   = in_heat;
    lc_nxt   = in_cool;
    ld_nxt   = in_done & ~term_r & ~abort_r;
    lp_nxt   = ~s_run & s_pwr;
    lr_nxt   = s_remote;
    hot_nxt  = (s_temp > rcpc_pkg::HOT_LIMIT);
    ar_nxt   = in_cool & abort_r;
    ad_nxt   = in_done & (abort_r | term_r);
    pi_nxt   = pwrint_r;
    lv_nxt   = in_initf;
    // Upper, lower, flow, temp, sensor, fan, heater lamps follow their causes.
    lf_nxt   = s_fault;
    if (test_r != 4'h0) begin
      dm_nxt = rcpc_pkg::DISP_TEST;
    end else if (in_initf || (|s_fault)) begin
      dm_nxt = rcpc_pkg::DISP_CODE;
    end else begin
      dm_nxt = rcpc_pkg::DISP_TIME;
    end
    dc_nxt = in_initf ? rcpc_pkg::CODE_E02 : {1'b0, s_fault};
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      heater_en_o         <= 1'b0;
      fan_en_o            <= 1'b0;
      valve_cool_cmd_o    <= 1'b0;
      door_unlatch_o      <= 1'b0;
      lamp_bypass_o       <= 1'b0;
      lamp_heat_o         <= 1'b0;
      lamp_cool_o         <= 1'b0;
      lamp_done_o         <= 1'b0;
      lamp_local_pause_o  <= 1'b0;
      lamp_remote_pause_o <= 1'b0;
      lamp_hot_o          <= 1'b0;
      lamp_abort_run_o    <= 1'b0;
      lamp_abort_done_o   <= 1'b0;
      lamp_pwr_int_o      <= 1'b0;
      lamp_valve_o        <= 1'b0;
      lamp_fault_o        <= '0;
      disp_mode_o         <= rcpc_pkg::DISP_TEST;
      disp_code_o         <= 8'h00;
      disp_time_o         <= 16'h0000;
    end else begin
      heater_en_o         <= heat_nxt;
      fan_en_o            <= fan_nxt;
      valve_cool_cmd_o    <= vcmd_nxt;
      door_unlatch_o      <= unl_nxt;
      lamp_bypass_o       <= byp_nxt;
      lamp_heat_o         <= lh_nxt;
      lamp_cool_o         <= lc_nxt;
      lamp_done_o         <= ld_nxt;
      lamp_local_pause_o  <= lp_nxt;
      lamp_remote_pause_o <= lr_nxt;
      lamp_hot_o          <= hot_nxt;
      lamp_abort_run_o    <= ar_nxt;
      lamp_abort_done_o   <= ad_nxt;
      lamp_pwr_int_o      <= pi_nxt;
      lamp_valve_o        <= lv_nxt;
      lamp_fault_o        <= lf_nxt;
      disp_mode_o         <= dm_nxt;
      disp_code_o         <= dc_nxt;
      disp_time_o         <= remain_r;
    end
  end

endmodule // rcpc_panel

// ### rcpc_panel_assertions.sv
// Purpose: Port-level checks for the regeneration panel controller.
// Assumes: Inputs stay steady long enough to pass the synchroniser.
// Notes:   Six stable samples cover sync, state and output register delay.
`timescale 1ns/1ps
module rcpc_panel_chk (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        bypass_sw_i,
  input wire logic [11:0] oven_temp_i,
  input wire logic [6:0]  fault_i,
  input wire logic [6:0]  lamp_fault_o,
  input wire logic        lamp_bypass_o,
  input wire logic        lamp_hot_o,
  input wire logic        lamp_heat_o,
  input wire logic        lamp_cool_o,
  input wire logic        lamp_done_o,
  input wire logic        heater_en_o,
  input wire logic        fan_en_o,
  input wire logic        lamp_valve_o,
  input wire logic [7:0]  disp_code_o,
  input wire logic        door_unlatch_o,
  input wire logic        lamp_abort_run_o,
  input wire logic        lamp_abort_done_o,
  input wire logic        lamp_local_pause_o
);
  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  AST_BYPASS_LAMP: assert property (
    $stable(bypass_sw_i)[*6] |-> lamp_bypass_o == bypass_sw_i) else $error("bypass lamp");
  AST_HOT_LAMP: assert property (
    $stable(oven_temp_i)[*6] |-> lamp_hot_o == (oven_temp_i > rcpc_pkg::HOT_LIMIT))
    else $error("hot lamp");
  AST_FAULT_LAMPS: assert property (
    $stable(fault_i)[*6] |-> lamp_fault_o == fault_i) else $error("fault lamps");
  AST_ONE_PHASE: assert property (
    $onehot0({lamp_heat_o, lamp_cool_o, lamp_done_o})) else $error("phase lamps");
  AST_HEATER_PHASE: assert property (
    heater_en_o |-> lamp_heat_o) else $error("heater outside heating");
  AST_E02_OUT: assert property (
    lamp_valve_o |-> disp_code_o == rcpc_pkg::CODE_E02 && !heater_en_o && !fan_en_o)
    else $error("initiation fault outputs");
  AST_DOOR_DONE: assert property (
    (door_unlatch_o == (lamp_done_o || lamp_abort_done_o)) &&
    !(door_unlatch_o && (fan_en_o || lamp_cool_o))) else $error("door unlatch");
  AST_ABORT_COOL: assert property (
    lamp_abort_run_o |-> lamp_cool_o && !lamp_abort_done_o) else $error("abort lamps");
  AST_PAUSE_STOP: assert property (
    (lamp_local_pause_o && lamp_heat_o)[*3] |-> !heater_en_o && !fan_en_o)
    else $error("pause drive");
endmodule // rcpc_panel_chk

bind rcpc_panel rcpc_panel_chk u_chk (.clk_i, .resetn_i, .bypass_sw_i, .oven_temp_i,
  .fault_i, .lamp_fault_o, .lamp_bypass_o, .lamp_hot_o, .lamp_heat_o, .lamp_cool_o,
  .lamp_done_o, .heater_en_o, .fan_en_o, .lamp_valve_o, .disp_code_o, .door_unlatch_o,
  .lamp_abort_run_o, .lamp_abort_done_o, .lamp_local_pause_o);

// ### rcpc_pkg.sv
// Purpose: Shared constants and types for the regeneration panel controller.
// Assumes: 250 MHz system clock; all timing in whole seconds after the tick.
// Notes:   Fault lamp vectors use the F_* bit positions below.
package rcpc_pkg;

  // ==========================================================================
  // Clock and tick
  localparam int CLK_HZ     = 250_000_000;
  localparam int TICK_S     = 1;
  localparam int TICK_CYC   = CLK_HZ * TICK_S;

  // ==========================================================================
  // Cycle timing, in seconds
  localparam int TW         = 16;
  localparam logic [TW-1:0] HEAT_S       = 16'h8ca0;  // 10 hours.
  localparam logic [TW-1:0] COOL_S       = 16'h3840;  // 4 hours.
  localparam logic [TW-1:0] TOTAL_S      = 16'hc4e0;  // 14 hours.
  localparam logic [TW-1:0] ABORT_COOL_S = 16'h5460;  // 6 hours.
  localparam logic [TW-1:0] PAUSE_MAX_S  = 16'h5460;  // 6 hours.
  localparam logic [TW-1:0] START_TO_S   = 16'h0384;  // 15 minutes.
  localparam logic [3:0]    SELFTEST_S   = 4'h3;

  // ==========================================================================
  // Sensing and display
  localparam int TEMPW      = 12;
  localparam logic [TEMPW-1:0] HOT_LIMIT = 12'h069;  // 105 degrees.
  localparam int NFAULT     = 7;
  localparam int F_UPPER    = 0;
  localparam int F_LOWER    = 1;
  localparam int F_FLOW     = 2;
  localparam int F_TEMP     = 3;
  localparam int F_SENSOR   = 4;
  localparam int F_FAN      = 5;
  localparam int F_HEATER   = 6;
  localparam logic [7:0] CODE_E02  = 8'h02;
  localparam logic [1:0] DISP_TIME = 2'h0;
  localparam logic [1:0] DISP_CODE = 2'h1;
  localparam logic [1:0] DISP_TEST = 2'h2;

  // ==========================================================================
  // Cycle states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_HEAT  = 5'h02,
    ST_COOL  = 5'h04,
    ST_DONE  = 5'h08,
    ST_INITF = 5'h10
  } rcpc_state_t;

endpackage

// ### rcpc_sync.sv
// Purpose: Two-stage synchroniser for a bundle of panel inputs.
// Assumes: Each bit is a slow level.
// Notes:   Multi-bit values may tear for one cycle while changing.
`timescale 1ns/1ps
module rcpc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // ==========================================================================
  // Stages
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d_i;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_o    <= q_nxt;
    end
  end

endmodule // rcpc_sync

// ### rcpc_testbench.sv
// Purpose: Self-checking bench for the regeneration panel controller.
// Assumes: Shortened counts; one tick every four clock cycles.
// Notes:   Every scenario starts from a fresh power-on reset.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: mismatch at line %0d", $time, `__LINE__); end end
`define WAITC(c) begin for (int k = 0; !(c); k++) begin if (k == 400) begin \
  fail_count++; $display("unexpected at %0t: wait ran out", $time); \
  tally_and_finish(); end cyc(1); end end
module testbench;
  // ==========================================================================
  // Signals and instances
  logic        clk_i = 1'b0, resetn_i = 1'b0, power_sw_i = 1'b1, run_sel_i = 1'b1;
  logic        bypass_sw_i = 1'b0, remote_pause_i = 1'b0, door_closed_i = 1'b1;
  logic        door_open90_i = 1'b0, valve_cool_i = 1'b0, press_s = 1'b0, press_d = 1'b0;
  logic [6:0]  fault_i = 7'h00, hazard_i = 7'h00, lamp_fault_o;
  logic [11:0] oven_temp_i = 12'h000;
  logic [1:0]  disp_mode_o;
  logic [7:0]  disp_code_o;
  logic [15:0] disp_time_o, t0;
  logic        start_btn_i, shutdown_btn_i, heater_en_o, fan_en_o, valve_cool_cmd_o;
  logic        door_unlatch_o, lamp_bypass_o, lamp_heat_o, lamp_cool_o, lamp_done_o;
  logic        lamp_local_pause_o, lamp_remote_pause_o, lamp_hot_o, lamp_abort_run_o;
  logic        lamp_abort_done_o, lamp_pwr_int_o, lamp_valve_o;
  int          fail_count = 0, tests_run = 0;
  // Short counts keep a full cycle near a hundred and twenty clocks.
  rcpc_panel #(.TICK_CYC(4), .HEAT_S(16'h0014), .COOL_S(16'h000a), .ABORT_S(16'h000c),
    .PAUSE_MAX_S(16'h0005), .START_TO_S(16'h0006)) DUT (.clk_i, .resetn_i, .power_sw_i,
    .run_sel_i, .start_btn_i, .shutdown_btn_i, .bypass_sw_i, .remote_pause_i, .door_closed_i,
    .door_open90_i, .valve_cool_i, .fault_i, .hazard_i, .oven_temp_i, .heater_en_o, .fan_en_o,
    .valve_cool_cmd_o, .door_unlatch_o, .lamp_bypass_o, .lamp_heat_o, .lamp_cool_o,
    .lamp_done_o, .lamp_local_pause_o, .lamp_remote_pause_o, .lamp_hot_o, .lamp_abort_run_o,
    .lamp_abort_done_o, .lamp_pwr_int_o, .lamp_valve_o, .lamp_fault_o, .disp_mode_o,
    .disp_code_o, .disp_time_o);
  rcpc_operator OPR (.clk_i, .press_start_i(press_s), .press_shut_i(press_d),
    .start_btn_o(start_btn_i), .shutdown_btn_o(shutdown_btn_i));
  initial forever #2 clk_i = ~clk_i;
  // ==========================================================================
  // Shared tasks
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // The wait after each press lets the synchroniser and edge detector settle.
  task automatic press(input logic s);
    press_s = s;
    press_d = !s;
    cyc(1);
    press_s = 1'b0;
    press_d = 1'b0;
    cyc(10);
  endtask
  task automatic pwr();
    power_sw_i = 1'b0;
    cyc(4);
    power_sw_i = 1'b1;
    cyc(16);
  endtask
  task automatic boot();
    resetn_i = 1'b0;
    {run_sel_i, bypass_sw_i, remote_pause_i, valve_cool_i} = 4'h8;
    {fault_i, hazard_i} = 14'h0000;
    cyc(8);
    `CHK(disp_mode_o, rcpc_pkg::DISP_TEST)
    resetn_i = 1'b1;
    cyc(2);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_lamps();
    boot();
    for (int i = 0; i < 7; i++) begin
      fault_i = 7'h01 << i;
      bypass_sw_i = i[0];
      oven_temp_i = 12'h069 + 12'(i[0]);
      cyc(6);
      `CHK(lamp_fault_o, 7'h01 << i)
      `CHK(lamp_bypass_o, i[0])
      `CHK(lamp_hot_o, i[0])
    end
  endtask
  task automatic t_full();
    boot();
    press(1'b1);
    `CHK({lamp_heat_o, heater_en_o, fan_en_o}, 3'h7)
    t0 = disp_time_o;
    cyc(8);
    `CHK(disp_time_o, t0 - 16'h0002)
    `WAITC(lamp_cool_o)
    `CHK(lamp_heat_o, 1'b0)
    `WAITC(lamp_done_o)
    `CHK({door_unlatch_o, fan_en_o, lamp_cool_o, lamp_abort_done_o}, 4'h8)
  endtask
  task automatic t_abort();
    boot();
    press(1'b1);
    press(1'b0);
    `CHK({lamp_cool_o, lamp_abort_run_o, lamp_heat_o}, 3'h6)
    `CHK(disp_time_o <= 16'h000c && disp_time_o >= 16'h0009, 1'b1)
    press(1'b1);
    `CHK(lamp_heat_o, 1'b0)
    `WAITC(lamp_abort_done_o)
    `CHK({lamp_abort_done_o, lamp_abort_run_o, lamp_done_o}, 3'h4)
  endtask
  task automatic t_pause();
    boot();
    press(1'b1);
    run_sel_i = 1'b0;
    cyc(6);
    `CHK({lamp_local_pause_o, heater_en_o, fan_en_o}, 3'h4)
    t0 = disp_time_o;
    cyc(8);
    `CHK({disp_time_o, lamp_heat_o}, {t0, 1'b1})
    run_sel_i = 1'b1;
    remote_pause_i = 1'b1;
    cyc(6);
    `CHK({lamp_remote_pause_o, lamp_local_pause_o, heater_en_o}, 3'h4)
    `WAITC(lamp_abort_done_o)
    `CHK({lamp_abort_done_o, lamp_done_o, lamp_heat_o}, 3'h4)
  endtask
  task automatic t_power_bypass();
    boot();
    bypass_sw_i = 1'b1;
    press(1'b1);
    fault_i = 7'h04;
    cyc(6);
    `CHK(heater_en_o, 1'b1)
    hazard_i = 7'h04;
    cyc(6);
    `CHK(heater_en_o, 1'b0)
    {hazard_i, bypass_sw_i} = 8'h00;
    cyc(6);
    `CHK(heater_en_o, 1'b0)
    fault_i = 7'h00;
    power_sw_i = 1'b0;
    cyc(6);
    `CHK({lamp_heat_o, lamp_pwr_int_o}, 2'h1)
    pwr();
    press(1'b1);
    `CHK({lamp_heat_o, heater_en_o, lamp_pwr_int_o}, 3'h6)
  endtask
  task automatic t_e02();
    boot();
    door_closed_i = 1'b0;
    cyc(40);
    `CHK(valve_cool_cmd_o, 1'b0)
    door_closed_i = 1'b1;
    cyc(12);
    `CHK(valve_cool_cmd_o, 1'b0)
    cyc(28);
    `CHK(valve_cool_cmd_o, 1'b1)
    valve_cool_i = 1'b1;
    press(1'b1);
    `CHK({lamp_valve_o, disp_code_o}, {1'b1, rcpc_pkg::CODE_E02})
    `CHK(disp_mode_o, rcpc_pkg::DISP_CODE)
    `CHK({heater_en_o, fan_en_o, lamp_heat_o}, 3'h0)
    pwr();
    press(1'b1);
    `CHK(lamp_valve_o, 1'b1)
    door_open90_i = 1'b1;
    cyc(4);
    door_open90_i = 1'b0;
    valve_cool_i = 1'b0;
    pwr();
    press(1'b1);
    `CHK({lamp_valve_o, lamp_heat_o, heater_en_o}, 3'h3)
  endtask
  initial begin
    t_lamps();
    t_full();
    t_abort();
    t_pause();
    t_power_bypass();
    t_e02();
    tally_and_finish();
  end
endmodule // testbench

// ### rcpc_tick.sv
// Purpose: Divides the system clock to a one-cycle enable pulse.
// Assumes: DIV is at least 2.
// Notes:   Pulse comes once every DIV cycles.
`timescale 1ns/1ps
module rcpc_tick #(
  parameter int DIV = 250_000_000
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  output logic      tick_o
);

  // ==========================================================================
  // Divider
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          tick_nxt;

  always_comb begin
    tick_nxt = (cnt_r == LAST);
    cnt_nxt  = tick_nxt ? '0 : cnt_r + 1'b1;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_o <= tick_nxt;
    end
  end

endmodule // rcpc_tick
